// ==== src/hmf_addr_check.v ====
`timescale 1ns/1ps
`default_nettype none
`include "hmf_defs.vh"
module hmf_addr_check (
	// address to test
	input  wire [47:0] dest_addr,
	input  wire [5:0]  hash_index,
	// settings
	input  wire [47:0] station_addr,
	input  wire [63:0] hash_table,
	input  wire [7:0]  ctrl,
	// result
	output wire        pass,
	output wire        is_group,
	output wire        is_no_broadcast_flag,
	output wire        exact_hit
);
	wire hash_hit;
	reg  pass_c;
	assign is_group  = dest_addr[0];                       // R20
	assign is_no_broadcast_flag  = (dest_addr == `HMF_NO_BROADCAST_FLAG_ADDR);
	assign exact_hit = (dest_addr == station_addr);
	// top index bit picks high word, low five bits pick the bit
	assign hash_hit  = hash_table[hash_index];             // R19
	assign pass      = pass_c;
	always @* begin
		pass_c = 1'b0;
		if (ctrl[`HMF_CR_ANY_DA]) begin
			pass_c = 1'b1;                                   // R3
		end else if (ctrl[`HMF_CR_INV_FILT]) begin
			pass_c = ~exact_hit;                             // R1 R2
		end else if (ctrl[`HMF_CR_PASS_GROUP] && is_group) begin
			pass_c = 1'b1;                                   // R6
		end else if (ctrl[`HMF_CR_HASH_ONLY]) begin
			pass_c = hash_hit || (is_no_broadcast_flag &&
				!ctrl[`HMF_CR_NO_NO_BROADCAST_FLAG]);                    // R5
		end else if (ctrl[`HMF_CR_HASH_PERF] && is_group) begin
			pass_c = hash_hit || (is_no_broadcast_flag &&
				!ctrl[`HMF_CR_NO_NO_BROADCAST_FLAG]);
		end else begin
			pass_c = exact_hit || (is_no_broadcast_flag &&
				!ctrl[`HMF_CR_NO_NO_BROADCAST_FLAG]);                    // R4
		end
	end
endmodule // hmf_addr_check
`default_nettype wire

// ==== src/hmf_defs.vh ====
`ifndef HMF_DEFS_VH
`define HMF_DEFS_VH
// register byte addresses
`define HMF_ADDR_STA_LO     12'h000
`define HMF_ADDR_STA_HI     12'h004
`define HMF_ADDR_HASH_LO    12'h008
`define HMF_ADDR_HASH_HI    12'h00C
`define HMF_ADDR_MAC_CTRL   12'h010
`define HMF_ADDR_PAUSE_CTRL 12'h014
`define HMF_ADDR_WAKE_CS    12'h018
`define HMF_ADDR_POWER_CTRL 12'h01C
`define HMF_ADDR_LAST_STAT  12'h020
// mac_ctrl_reg fields
`define HMF_CR_NO_NO_BROADCAST_FLAG     0
`define HMF_CR_ANY_DA       1
`define HMF_CR_PASS_GROUP   2
`define HMF_CR_INV_FILT     3
`define HMF_CR_HASH_ONLY    4
`define HMF_CR_HASH_PERF    5
`define HMF_CR_ACCEPT_ALL   6
`define HMF_CR_KEEP_ERR     7
`define HMF_CR_WIDTH        8
// pause_ctrl_reg fields
`define HMF_FL_PASS_PAUSE   0
// wake_ctrl_stat fields
`define HMF_WU_EXACT_EN     0
`define HMF_WU_NO_BROADCAST_FLAG_EN     1
`define HMF_WU_PATTERN_EN   2
`define HMF_WU_MAGIC_EN     3
`define HMF_WU_DEFER        4
`define HMF_WU_EXACT_SEEN   5
`define HMF_WU_NO_BROADCAST_FLAG_SEEN   6
`define HMF_WU_WIDTH        7
// power_ctrl_reg fields
`define HMF_PM_EVENT_FLAG   0
`define HMF_PM_EVENT_EN     1
`define HMF_PM_SLEEP        2
// error frame size limit in bytes
`define HMF_SHORT_LEN       14'd60
`define HMF_NO_BROADCAST_FLAG_ADDR      48'hFFFFFFFFFFFF
`endif

// ==== src/hmf_rx_filter.v ====
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "hmf_defs.vh"
// Notes on behaviour
// R1 - inverse mode: accept non-matching, reject matching
// R2 - inverse mode rejects broadcast if station broadcast
// R3 - any-da mode accepts every frame
// R4 - physical addresses exactly matched in multicast mode
// R5 - hash-only multicast mode hashes physical addresses
// R6 - pass group accepts all multicast and broadcast
// R7 - good passing frame: fail clear, filter set
// R8 - good failing frame needs accept everything
// R9 - broadcast filter flag is inverse of no_broadcast
// R10 - control frame filter flag copies pass pause
// R11 - long errored frame filter flag copies keep
// R12 - short errored frame needs pass or both
// R13 - wake only from enabled detection types
// R14 - defer wake detection until sleep state
// R15 - wake flag reported, output needs event enable
// R16 - exact wake mode suspends rx, sets seen
// R17 - broadcast wake mode suspends rx, sets seen
// R18 - station address is high and low concatenated
// R19 - hash index: top bit word, five bits bit
// R20 - first transmitted bit one means multicast
// R21 - seen flags sticky until software clear or reset
module hmf_rx_filter (
	// clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// frame decision request from fabric port
	input  wire        frm_valid,
	input  wire [47:0] frm_dest,
	input  wire [5:0]  frm_hash,
	input  wire [13:0] frm_len,
	input  wire        frm_error,
	input  wire        frm_control,
	input  wire        frm_pattern_hit,
	input  wire        frm_magic_hit,
	// decision
	output reg         dec_valid,
	output reg         dec_accept,
	output reg         dec_filter_fail,
	output reg         dec_packet_filter,
	// power management
	output reg         power_event_out
);
	////////////////////////////////////////////////////////////////
	reg  [31:0] station_addr_low_q;
	reg  [15:0] station_addr_high_q;
	reg  [31:0] hash_table_low_q;
	reg  [31:0] hash_table_high_q;
	reg  [7:0]  mac_ctrl_reg_q;
	reg         pause_ctrl_reg_q;
	reg  [6:0]  wake_ctrl_stat_q;
	reg  [6:0]  wake_ctrl_stat_d;
	reg  [2:0]  power_ctrl_reg_q;
	reg  [2:0]  power_ctrl_reg_d;
	reg  [3:0]  last_stat_q;
	wire [47:0] station_addr;
	wire        pass;
	wire        is_group;
	wire        is_no_broadcast_flag;
	wire        exact_hit;
	wire        wr_en;
	wire        rd_en;
	wire        wake_mode;
	wire        wake_armed;
	wire        exact_det;
	wire        no_broadcast_flag_det;
	wire        wake_det;
	wire [3:0]  det_src;
	wire [3:0]  det_hit;
	wire        is_long;
	reg         acc_c;
	reg         pf_c;
	reg         map_hit;
	reg  [31:0] rd_c;

	assign station_addr = {station_addr_high_q, station_addr_low_q}; // R18

	hmf_addr_check u_check (
		.dest_addr    (frm_dest),
		.hash_index   (frm_hash),
		.station_addr (station_addr),
		.hash_table   ({hash_table_high_q, hash_table_low_q}),
		.ctrl         (mac_ctrl_reg_q),
		.pass         (pass),
		.is_group     (is_group),
		.is_no_broadcast_flag     (is_no_broadcast_flag),
		.exact_hit    (exact_hit)
	);

	////////////////////////////////////////////////////////////////
	// apb: one wait state, so pready rises in the second access cycle
	assign wr_en = psel && penable && pwrite && pready;
	assign rd_en = psel && penable && !pwrite;

	always @* begin
		map_hit = 1'b1;
		rd_c    = 32'h00000000;
		if (paddr == `HMF_ADDR_STA_LO) begin
			rd_c = station_addr_low_q;
		end else if (paddr == `HMF_ADDR_STA_HI) begin
			rd_c = {16'h0000, station_addr_high_q};
		end else if (paddr == `HMF_ADDR_HASH_LO) begin
			rd_c = hash_table_low_q;
		end else if (paddr == `HMF_ADDR_HASH_HI) begin
			rd_c = hash_table_high_q;
		end else if (paddr == `HMF_ADDR_MAC_CTRL) begin
			rd_c = {24'h000000, mac_ctrl_reg_q};
		end else if (paddr == `HMF_ADDR_PAUSE_CTRL) begin
			rd_c = {31'h00000000, pause_ctrl_reg_q};
		end else if (paddr == `HMF_ADDR_WAKE_CS) begin
			rd_c = {25'h0000000, wake_ctrl_stat_q};
		end else if (paddr == `HMF_ADDR_POWER_CTRL) begin
			rd_c = {29'h00000000, power_ctrl_reg_q};
		end else if (paddr == `HMF_ADDR_LAST_STAT) begin
			rd_c = {28'h0000000, last_stat_q};
		end else begin
			map_hit = 1'b0;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !map_hit;
			if (rd_en && !pready) begin
				prdata <= rd_c;
			end
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			station_addr_low_q  <= 32'h00000000;
			station_addr_high_q <= 16'h0000;
			hash_table_low_q    <= 32'h00000000;
			hash_table_high_q   <= 32'h00000000;
			mac_ctrl_reg_q      <= 8'h00;
			pause_ctrl_reg_q    <= 1'b0;
		end else if (wr_en) begin
			if (paddr == `HMF_ADDR_STA_LO) begin
				station_addr_low_q <= pwdata;
			end else if (paddr == `HMF_ADDR_STA_HI) begin
				station_addr_high_q <= pwdata[15:0];
			end else if (paddr == `HMF_ADDR_HASH_LO) begin
				hash_table_low_q <= pwdata;
			end else if (paddr == `HMF_ADDR_HASH_HI) begin
				hash_table_high_q <= pwdata;
			end else if (paddr == `HMF_ADDR_MAC_CTRL) begin
				mac_ctrl_reg_q <= pwdata[7:0];
			end else if (paddr == `HMF_ADDR_PAUSE_CTRL) begin
				pause_ctrl_reg_q <= pwdata[`HMF_FL_PASS_PAUSE];
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// wake detection
	assign wake_mode  = wake_ctrl_stat_q[`HMF_WU_EXACT_EN] ||
		wake_ctrl_stat_q[`HMF_WU_NO_BROADCAST_FLAG_EN] ||
		wake_ctrl_stat_q[`HMF_WU_PATTERN_EN] ||
		wake_ctrl_stat_q[`HMF_WU_MAGIC_EN];
	assign wake_armed = !wake_ctrl_stat_q[`HMF_WU_DEFER] ||
		power_ctrl_reg_q[`HMF_PM_SLEEP];                   // R14
	// detector order matches the enable bit order in wake_ctrl_stat
	assign det_src = {frm_magic_hit, frm_pattern_hit, is_no_broadcast_flag, exact_hit};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_det
			assign det_hit[gi] = frm_valid && wake_armed && det_src[gi] &&
				wake_ctrl_stat_q[`HMF_WU_EXACT_EN + gi];   // R13
		end
	endgenerate

	assign exact_det = det_hit[0];                         // R16
	assign no_broadcast_flag_det = det_hit[1];                         // R17
	assign wake_det  = |det_hit;                           // R13

	// seen flags are write-one-to-clear; a detection wins over the clear
	always @* begin
		wake_ctrl_stat_d = wake_ctrl_stat_q;
		power_ctrl_reg_d = power_ctrl_reg_q;
		if (wr_en && paddr == `HMF_ADDR_WAKE_CS) begin
			wake_ctrl_stat_d[4:0] = pwdata[4:0];
			if (pwdata[`HMF_WU_EXACT_SEEN])
				wake_ctrl_stat_d[`HMF_WU_EXACT_SEEN] = 1'b0;
			if (pwdata[`HMF_WU_NO_BROADCAST_FLAG_SEEN])
				wake_ctrl_stat_d[`HMF_WU_NO_BROADCAST_FLAG_SEEN] = 1'b0;
		end
		if (wr_en && paddr == `HMF_ADDR_POWER_CTRL) begin
			power_ctrl_reg_d[`HMF_PM_EVENT_EN] = pwdata[`HMF_PM_EVENT_EN];
			power_ctrl_reg_d[`HMF_PM_SLEEP]    = pwdata[`HMF_PM_SLEEP];
			if (pwdata[`HMF_PM_EVENT_FLAG])
				power_ctrl_reg_d[`HMF_PM_EVENT_FLAG] = 1'b0;
		end
		if (exact_det)
			wake_ctrl_stat_d[`HMF_WU_EXACT_SEEN] = 1'b1;   // R21
		if (no_broadcast_flag_det)
			wake_ctrl_stat_d[`HMF_WU_NO_BROADCAST_FLAG_SEEN] = 1'b1;   // R21
		if (wake_det)
			power_ctrl_reg_d[`HMF_PM_EVENT_FLAG] = 1'b1;   // R15
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_ctrl_stat_q <= 7'h00;
			power_ctrl_reg_q <= 3'h0;
			power_event_out  <= 1'b0;
		end else begin
			wake_ctrl_stat_q <= wake_ctrl_stat_d;
			power_ctrl_reg_q <= power_ctrl_reg_d;
			power_event_out  <= power_ctrl_reg_d[`HMF_PM_EVENT_FLAG] &&
				power_ctrl_reg_d[`HMF_PM_EVENT_EN];        // R15
		end
	end

	////////////////////////////////////////////////////////////////
	// frame acceptance
	assign is_long = (frm_len > `HMF_SHORT_LEN);

	always @* begin
		acc_c = 1'b0;
		pf_c  = 1'b1;
		if (frm_error && !is_long) begin
			acc_c = pass || (mac_ctrl_reg_q[`HMF_CR_ACCEPT_ALL] &&
				mac_ctrl_reg_q[`HMF_CR_KEEP_ERR]);         // R12
			pf_c  = 1'b1;
		end else if (frm_error) begin
			acc_c = pass || mac_ctrl_reg_q[`HMF_CR_ACCEPT_ALL];
			pf_c  = mac_ctrl_reg_q[`HMF_CR_KEEP_ERR];      // R11
		end else begin
			acc_c = pass || mac_ctrl_reg_q[`HMF_CR_ACCEPT_ALL]; // R7 R8
			if (frm_control)
				pf_c = pause_ctrl_reg_q;                   // R10
			else if (is_no_broadcast_flag)
				pf_c = !mac_ctrl_reg_q[`HMF_CR_NO_NO_BROADCAST_FLAG];  // R9
		end
		// wake detection modes suspend normal reception
		if (wake_mode)
			acc_c = 1'b0;                                  // R16 R17
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dec_valid         <= 1'b0;
			dec_accept        <= 1'b0;
			dec_filter_fail   <= 1'b0;
			dec_packet_filter <= 1'b0;
			last_stat_q       <= 4'h0;
		end else begin
			dec_valid <= frm_valid;
			if (frm_valid) begin
				dec_accept        <= acc_c;
				dec_filter_fail   <= !pass;
				dec_packet_filter <= pf_c;
				last_stat_q       <= {1'b1, acc_c, !pass, pf_c};
			end
		end
	end
endmodule // hmf_rx_filter
`default_nettype wire

// ==== verification/hmf_fabric_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module hmf_fabric_model (
	// clock
	input  wire logic        pclk,
	// frame lines
	output var  logic        frm_valid,
	output var  logic [47:0] frm_dest,
	output var  logic [5:0]  frm_hash,
	output var  logic [13:0] frm_len,
	output var  logic [3:0]  frm_flags
);
	initial {frm_valid, frm_dest, frm_hash, frm_len, frm_flags} = '0;
	// fields inverted outside a frame so stale values can never match
	task send(input logic [47:0] d, input logic [5:0] h,
		input logic [13:0] l, input logic [3:0] f);
		@(posedge pclk);
		frm_valid <= 1'b1;
		{frm_dest, frm_hash, frm_len, frm_flags} <= {d, h, l, f};
		@(posedge pclk);
		frm_valid <= 1'b0;
		{frm_dest, frm_hash, frm_len, frm_flags} <= ~{d, h, l, f};
	endtask
endmodule // hmf_fabric_model
`default_nettype wire

// ==== verification/hmf_rx_filter_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "hmf_defs.vh"
module hmf_rx_filter_asserts (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic        pready,
	input wire logic        pslverr,
	// frame
	input wire logic        frm_valid,
	input wire logic [47:0] frm_dest,
	input wire logic [13:0] frm_len,
	input wire logic        frm_error,
	input wire logic        frm_control,
	// decision
	input wire logic        dec_valid,
	input wire logic        dec_accept,
	input wire logic        dec_filter_fail,
	input wire logic        dec_packet_filter,
	input wire logic        power_event_out
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_dec_follows: assert property (frm_valid |=> dec_valid)
		else $error("decision missing after frame");
	chk_dec_quiet: assert property (!frm_valid |=> !dec_valid)
		else $error("decision without frame");
	chk_dec_held: assert property (!dec_valid |-> $stable({dec_accept,
		dec_filter_fail, dec_packet_filter})) else $error("decision moved");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_ready_wait: assert property (pready |-> psel && penable &&
		$past(psel) && $past(penable)) else $error("pready too early");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	chk_good_pf: assert property (
		dec_valid && dec_accept && !$past(frm_error) && !$past(frm_control)
		&& $past(frm_dest) != `HMF_NO_BROADCAST_FLAG_ADDR |-> dec_packet_filter)
		else $error("good frame without packet filter");
	chk_short_pf: assert property (
		dec_valid && dec_accept && $past(frm_error)
		&& $past(frm_len) <= `HMF_SHORT_LEN |-> dec_packet_filter)
		else $error("short errored frame without packet filter");
	chk_power_cause: assert property (
		$rose(power_event_out) |-> $past(frm_valid)
		|| ($past(psel) && $past(penable) && $past(pwrite)))
		else $error("power event without cause");
	cover property (dec_valid && dec_accept && dec_filter_fail);
	cover property (pready && pslverr);
	cover property ($rose(power_event_out));
endmodule // hmf_rx_filter_asserts
bind hmf_rx_filter hmf_rx_filter_asserts u_hmf_rx_filter_asserts (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pready(pready), .pslverr(pslverr),
	.frm_valid(frm_valid), .frm_dest(frm_dest), .frm_len(frm_len),
	.frm_error(frm_error), .frm_control(frm_control),
	.dec_valid(dec_valid), .dec_accept(dec_accept),
	.dec_filter_fail(dec_filter_fail),
	.dec_packet_filter(dec_packet_filter),
	.power_event_out(power_event_out));
`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "hmf_defs.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
	bad_count++; $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module tb;
	localparam logic [47:0] ST = 48'h00ABCDEF1234;
	localparam logic [47:0] OT = 48'h00ABCDEF1236;
	localparam logic [47:0] MC = 48'h0100005E0001;
	localparam logic [47:0] BC = `HMF_NO_BROADCAST_FLAG_ADDR;
	localparam logic [13:0] L64 = 14'h0040;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        er, fv, dv, da, dff, dpf, pwr;
	logic [47:0] fd;
	logic [5:0]  fh;
	logic [13:0] fl;
	logic [3:0]  ff;
	int          bad_count = 0;
	int          compares = 0;
	hmf_fabric_model u_hmf_fabric_model (.pclk(pclk), .frm_valid(fv),
		.frm_dest(fd), .frm_hash(fh), .frm_len(fl), .frm_flags(ff));
	hmf_rx_filter u_hmf_rx_filter (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .frm_valid(fv), .frm_dest(fd), .frm_hash(fh),
		.frm_len(fl), .frm_error(ff[3]), .frm_control(ff[2]),
		.frm_pattern_hit(ff[1]), .frm_magic_hit(ff[0]), .dec_valid(dv),
		.dec_accept(da), .dec_filter_fail(dff), .dec_packet_filter(dpf),
		.power_event_out(pwr));
	////////////////////////////////////////
	task test_done;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		// a lost answer counts once, then the bench carries on
		if (pready !== 1'b1)
			bad_count++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rdc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK("prdata", e, rd)
	endtask
	// e is {accept, filter fail, packet filter}; flags only when accepted
	task fr(input logic [47:0] d, input logic [5:0] h, input logic [13:0] l,
		input logic [3:0] f, input logic [2:0] e);
		u_hmf_fabric_model.send(d, h, l, f);
		#1;
		`CHK("dec_valid", 1'b1, dv)
		`CHK("dec_accept", e[2], da)
		if (e[2])
			`CHK("dec_flags", e[1:0], {dff, dpf})
	endtask
	task t_regs;
		rdc(`HMF_ADDR_MAC_CTRL, 32'h0);
		wr(`HMF_ADDR_STA_LO, 32'hCDEF1234);
		wr(`HMF_ADDR_STA_HI, 32'h000000AB);
		rdc(`HMF_ADDR_STA_HI, 32'h000000AB);
		apb(1'b0, 12'h040, 32'h0);
		`CHK("pslverr", 1'b1, er)
		`CHK("unmapped", 32'h0, rd)
	endtask
	task t_inv;
		wr(`HMF_ADDR_MAC_CTRL, 32'h08);
		fr(ST, 6'h00, L64, 4'h0, 3'b000);
		fr(OT, 6'h00, L64, 4'h0, 3'b101);
		wr(`HMF_ADDR_STA_LO, 32'hFFFFFFFF);
		wr(`HMF_ADDR_STA_HI, 32'h0000FFFF);
		fr(BC, 6'h3F, L64, 4'h0, 3'b000);
		wr(`HMF_ADDR_STA_LO, 32'hCDEF1234);
		wr(`HMF_ADDR_STA_HI, 32'h000000AB);
	endtask
	task t_modes;
		wr(`HMF_ADDR_MAC_CTRL, 32'h03);
		fr(BC, 6'h00, L64, 4'h0, 3'b100);
		fr(OT, 6'h00, L64, 4'h0, 3'b101);
		wr(`HMF_ADDR_MAC_CTRL, 32'h00);
		fr(BC, 6'h00, L64, 4'h0, 3'b101);
		fr(ST, 6'h00, L64, 4'h0, 3'b101);
		fr(OT, 6'h00, L64, 4'h0, 3'b000);
		wr(`HMF_ADDR_MAC_CTRL, 32'h04);
		fr(MC, 6'h00, L64, 4'h0, 3'b101);
		fr(OT, 6'h00, L64, 4'h0, 3'b000);
		fr(ST, 6'h00, L64, 4'h0, 3'b101);
		wr(`HMF_ADDR_HASH_HI, 32'h80000000);
		wr(`HMF_ADDR_MAC_CTRL, 32'h34);
		fr(OT, 6'h3F, L64, 4'h0, 3'b101);
		fr(ST, 6'h1F, L64, 4'h0, 3'b000);
		fr(MC, 6'h00, L64, 4'h0, 3'b101);
	endtask
	task t_status;
		wr(`HMF_ADDR_MAC_CTRL, 32'h40);
		fr(OT, 6'h00, L64, 4'h0, 3'b111);
		fr(OT, 6'h00, L64, 4'h4, 3'b110);
		wr(`HMF_ADDR_PAUSE_CTRL, 32'h1);
		fr(ST, 6'h00, L64, 4'h4, 3'b101);
		fr(OT, 6'h00, 14'h003D, 4'h8, 3'b110);
		fr(OT, 6'h00, 14'h003C, 4'h8, 3'b000);
		wr(`HMF_ADDR_MAC_CTRL, 32'hC0);
		fr(OT, 6'h00, 14'h003C, 4'h8, 3'b111);
		wr(`HMF_ADDR_MAC_CTRL, 32'h00);
		fr(ST, 6'h00, 14'h003C, 4'h8, 3'b101);
		rdc(`HMF_ADDR_LAST_STAT, 32'hD);
	endtask
	task t_wake;
		wr(`HMF_ADDR_POWER_CTRL, 32'h2);
		wr(`HMF_ADDR_WAKE_CS, 32'h01);
		fr(ST, 6'h00, L64, 4'h0, 3'b000);
		rdc(`HMF_ADDR_WAKE_CS, 32'h21);
		`CHK("power_event_out", 1'b1, pwr)
		rdc(`HMF_ADDR_POWER_CTRL, 32'h3);
		wr(`HMF_ADDR_WAKE_CS, 32'h20);
		rdc(`HMF_ADDR_WAKE_CS, 32'h0);
		fr(ST, 6'h00, L64, 4'h0, 3'b101);
		wr(`HMF_ADDR_POWER_CTRL, 32'h1);
		wr(`HMF_ADDR_WAKE_CS, 32'h02);
		fr(OT, 6'h00, L64, 4'h0, 3'b000);
		rdc(`HMF_ADDR_WAKE_CS, 32'h02);
		fr(BC, 6'h00, L64, 4'h0, 3'b000);
		rdc(`HMF_ADDR_WAKE_CS, 32'h42);
		`CHK("power_event_out", 1'b0, pwr)
		rdc(`HMF_ADDR_POWER_CTRL, 32'h1);
		wr(`HMF_ADDR_WAKE_CS, 32'h52);
		wr(`HMF_ADDR_POWER_CTRL, 32'h1);
		fr(BC, 6'h00, L64, 4'h0, 3'b000);
		rdc(`HMF_ADDR_WAKE_CS, 32'h12);
		wr(`HMF_ADDR_POWER_CTRL, 32'h4);
		fr(BC, 6'h00, L64, 4'h0, 3'b000);
		rdc(`HMF_ADDR_WAKE_CS, 32'h52);
		wr(`HMF_ADDR_WAKE_CS, 32'h40);
		wr(`HMF_ADDR_POWER_CTRL, 32'h1);
		fr(OT, 6'h00, L64, 4'h2, 3'b000);
		rdc(`HMF_ADDR_POWER_CTRL, 32'h0);
		wr(`HMF_ADDR_WAKE_CS, 32'h04);
		fr(OT, 6'h00, L64, 4'h2, 3'b000);
		rdc(`HMF_ADDR_POWER_CTRL, 32'h1);
	endtask
	////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// run needs well under a thousand cycles
	initial begin
		#(50 * 3000);
		bad_count++;
		test_done;
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_inv;
		t_modes;
		t_status;
		t_wake;
		test_done;
	end
endmodule // tb
`default_nettype wire
